// [host_model.sv]
/*
 * host controller model: periodic supervision answers and the restart bit array.
 * assumes the bench drives ack_on and calls restart() from its own process.
 */
`timescale 1ns/1ps
module host_model (
    input  wire logic        CLK,
    input  wire logic        ack_on,
    output logic             HOST_ACK,
    output logic [95:0]      RESTART_ARRAY
);
    logic [1:0] phase = 2'h0;

    initial RESTART_ARRAY = 96'h0;

    always @(posedge CLK) begin
        phase <= phase + 2'h1;
    end

    // answer once every four cycles while the host is alive
    assign HOST_ACK = ack_on & (phase == 2'h0);

    // bit n mod 16 of word n div 16, held on for three cycles, then off
    task automatic restart(input int n);
        @(posedge CLK);
        RESTART_ARRAY[16 * (n / 16) + n % 16] <= 1'b1;
        repeat (3) @(posedge CLK);
        RESTART_ARRAY[16 * (n / 16) + n % 16] <= 1'b0;
    endtask
endmodule

// [unit_error_restart_control.sv]
/*
 * unit error and restart control of an analog input unit: host supervision,
 * type and unit number checks, restart on an on-then-off restart bit, APB registers.
 * assumes a single clock, synchronous inputs and a host that pulses HOST_ACK.
 */
`timescale 1ns/1ps
module unit_error_restart_control
    import unit_error_restart_pkg::*;
#(
    parameter int          SUPERVISION = SUPERVISION_CYCLES,
    parameter logic [7:0]  FITTED_TYPE = 8'h5a  // arbitrary type code
) (
    input  wire logic                CLK,
    input  wire logic                RST_B,
    input  wire logic                PSEL,
    input  wire logic                PENABLE,
    input  wire logic                PWRITE,
    input  wire logic [11:0]         PADDR,
    input  wire logic [31:0]         PWDATA,
    output logic      [31:0]         PRDATA,
    output logic                     PREADY,
    output logic                     PSLVERR,
    input  wire logic [6:0]          UNIT_NUMBER,
    input  wire logic                DUPLICATE_UNIT,
    input  wire logic [7:0]          TABLE_TYPE,
    input  wire logic                HOST_ACK,
    input  wire logic [95:0]         RESTART_ARRAY,
    input  wire logic [15:0]         CONV_DATA,
    input  wire logic                CONV_VALID,
    output logic      [15:0]         CONV_OUT,
    output logic                     RUN_IND,
    output logic                     HOST_ERR_IND
);

    if (SUPERVISION < 2 || SUPERVISION > 65535) begin : g_bad_supervision
        $error("SUPERVISION out of range");
    end
    if (INIT_CYCLES < 8 || INIT_CYCLES > 255) begin : g_bad_init
        $error("INIT_CYCLES out of range");
    end
    if (RESTART_WORDS * WORD_BITS != UNIT_MAX + 1) begin : g_bad_map
        $error("restart array size does not match unit range");
    end

    // *****************************************
    // helpers
    // *****************************************
    function automatic logic unit_ok(input logic [6:0] n);
        return n <= 7'(UNIT_MAX);
    endfunction

    function automatic logic restart_bit_of(input logic [95:0] arr, input logic [6:0] n);
        logic [15:0] word;
        word = arr[n[6:4] * WORD_BITS +: WORD_BITS];
        return unit_ok(n) ? word[n[3:0]] : 1'b0;
    endfunction

    // *****************************************
    // state
    // *****************************************
    unit_state_t state;
    unit_state_t next_state;
    logic [7:0]  init_cnt;
    logic [15:0] wd_cnt;
    logic        host_err;
    logic        type_err;
    logic        dup_err;
    logic [6:0]  unit;
    logic        restart_seen;
    logic [15:0] config_word;
    logic [15:0] active_cfg;

    wire logic restart_now   = restart_bit_of(RESTART_ARRAY, unit);
    wire logic restart_pulse = restart_seen & ~restart_now;
    wire logic init_done     = (state == ST_INIT) && (init_cnt == 8'(INIT_CYCLES - 1));
    wire logic bad_unit      = ~unit_ok(UNIT_NUMBER) | DUPLICATE_UNIT;
    wire logic bad_type      = TABLE_TYPE != FITTED_TYPE;
    wire logic wd_expire     = (state == ST_RUN) && !HOST_ACK && (wd_cnt == 16'(SUPERVISION - 1));
    wire logic restarting    = (state == ST_INIT) | restart_seen;

    // *****************************************
    // restart detection
    // *****************************************
    always_ff @(posedge CLK) begin
        if (!RST_B)
            restart_seen <= 1'b0;
        else
            restart_seen <= restart_now;
    end

    // *****************************************
    // state machine
    // *****************************************
    always_comb begin
        next_state = state;
        unique case (state)
            ST_INIT: begin
                if (init_done)
                    next_state = (bad_unit | bad_type) ? ST_STOP : ST_RUN;
            end
            ST_RUN:  next_state = state;
            ST_STOP: next_state = state;
        endcase
        if (restart_pulse)
            next_state = ST_INIT;
    end

    always_ff @(posedge CLK) begin
        if (!RST_B)
            state <= ST_INIT;
        else
            state <= next_state;
    end

    always_ff @(posedge CLK) begin
        if (!RST_B || state != ST_INIT || restart_pulse)
            init_cnt <= 8'h00;
        else
            init_cnt <= init_cnt + 8'h01;
    end

    // init latches settings, unit number and error causes
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            active_cfg <= CONFIG_RESET;
            unit       <= 7'h00;
            type_err   <= 1'b0;
            dup_err    <= 1'b0;
        end else if (init_done && !restart_pulse) begin
            active_cfg <= config_word;
            unit       <= UNIT_NUMBER;
            type_err   <= bad_type;
            dup_err    <= bad_unit;
        end
    end

    // *****************************************
    // host supervision
    // *****************************************
    always_ff @(posedge CLK) begin
        if (!RST_B || HOST_ACK || state != ST_RUN)
            wd_cnt <= 16'h0000;
        else if (!wd_expire)
            wd_cnt <= wd_cnt + 16'h0001;
    end

    always_ff @(posedge CLK) begin
        if (!RST_B)
            host_err <= 1'b0;
        else if (wd_expire)
            host_err <= 1'b1;
        else if (init_done)
            host_err <= 1'b0;
    end

    // *****************************************
    // outputs
    // *****************************************
    wire logic conv_take = (next_state == ST_RUN) && !host_err && !wd_expire
                           && CONV_VALID && active_cfg[CFG_ENABLE_BIT];

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            CONV_OUT     <= 16'h0000;
            RUN_IND      <= 1'b0;
            HOST_ERR_IND <= 1'b0;
        end else begin
            if (restarting || restart_now || next_state == ST_INIT)
                CONV_OUT <= 16'h0000;
            else if (conv_take)
                CONV_OUT <= CONV_DATA;
            RUN_IND      <= next_state == ST_RUN;
            HOST_ERR_IND <= host_err | wd_expire;
        end
    end

    // *****************************************
    // APB slave
    // *****************************************
    wire logic        apb_access = PSEL & PENABLE;
    wire logic        apb_done   = apb_access & PREADY;
    wire logic        hit_config = PADDR == REG_CONFIG;
    wire logic        hit_active = PADDR == REG_ACTIVE;
    wire logic        hit_status = PADDR == REG_STATUS;
    wire logic        hit_conv   = PADDR == REG_CONV;
    wire logic        mapped     = hit_config | hit_active | hit_status | hit_conv;
    wire logic [31:0] status_word = (32'(unit) << STS_UNIT_LSB)
                                  | (32'(restarting) << STS_RESTARTING)
                                  | (32'(state == ST_RUN) << STS_RUN)
                                  | (32'(dup_err) << STS_DUP_ERR)
                                  | (32'(type_err) << STS_TYPE_ERR)
                                  | (32'(host_err) << STS_HOST_ERR);
    wire logic [31:0] read_word  = hit_config ? {16'h0000, config_word} :
                                   hit_active ? {16'h0000, active_cfg} :
                                   hit_status ? status_word :
                                   hit_conv   ? {16'h0000, CONV_OUT} : 32'h00000000;

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h00000000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= apb_access & ~PREADY;
            PSLVERR <= apb_access & ~PREADY & ~mapped;
            if (apb_access && !PREADY && !PWRITE)
                PRDATA <= read_word;
        end
    end

    // settings are staged here and copied over only at init
    always_ff @(posedge CLK) begin
        if (!RST_B)
            config_word <= CONFIG_RESET;
        else if (apb_done && PWRITE && hit_config)
            config_word <= PWDATA[15:0];
    end

    // *****************************************
    // checks
    // *****************************************
    chk_host_err_flag: assert property (@(posedge CLK) disable iff (!RST_B)
        wd_expire |=> host_err ##1 HOST_ERR_IND)
        else $error("host timeout not flagged");

    chk_hold_on_err: assert property (@(posedge CLK) disable iff (!RST_B)
        (host_err && !restart_now && !restart_seen && state == ST_RUN) |=> $stable(CONV_OUT))
        else $error("output changed during host error");

    chk_type_blocks_run: assert property (@(posedge CLK) disable iff (!RST_B)
        (init_done && bad_type && !restart_pulse) |=> state == ST_STOP && type_err ##1 !RUN_IND)
        else $error("type mismatch did not stop the unit");

    chk_cfg_at_init: assert property (@(posedge CLK) disable iff (!RST_B)
        !init_done |=> $stable(active_cfg))
        else $error("active settings changed outside init");

    chk_restart_seq: assert property (@(posedge CLK) disable iff (!RST_B)
        (restart_now ##1 !restart_now) |=> state == ST_INIT [*8])
        else $error("restart sequence not honoured");

    chk_restart_map: assert property (@(posedge CLK) disable iff (!RST_B)
        unit_ok(unit) |-> restart_now == RESTART_ARRAY[unit])
        else $error("restart bit mapping wrong");

    chk_zero_restart: assert property (@(posedge CLK) disable iff (!RST_B)
        (state == ST_INIT) |=> CONV_OUT == 16'h0000)
        else $error("conversion data not zero in restart");

    chk_dup_no_run: assert property (@(posedge CLK) disable iff (!RST_B)
        (init_done && bad_unit && !restart_pulse) |=> dup_err && !RUN_IND && state == ST_STOP)
        else $error("bad unit number allowed to run");

    chk_run_ind_state: assert property (@(posedge CLK) disable iff (!RST_B)
        RUN_IND == (state == ST_RUN))
        else $error("run indicator disagrees with state");

    chk_stop_run_off: assert property (@(posedge CLK) disable iff (!RST_B)
        ((dup_err || type_err) && state != ST_INIT) |-> !RUN_IND)
        else $error("run indicator on with a unit error");

    chk_host_err_sticky: assert property (@(posedge CLK) disable iff (!RST_B)
        (host_err && !init_done) |=> host_err)
        else $error("host error cleared outside init");

    chk_err_ind_follow: assert property (@(posedge CLK) disable iff (!RST_B)
        host_err |=> HOST_ERR_IND)
        else $error("host error indicator not lit");

    chk_wd_bound: assert property (@(posedge CLK) disable iff (!RST_B)
        wd_cnt <= 16'(SUPERVISION - 1))
        else $error("supervision counter past its limit");

    chk_ack_clears_wd: assert property (@(posedge CLK) disable iff (!RST_B)
        HOST_ACK |=> wd_cnt == 16'h0000)
        else $error("host answer did not restart supervision");

    chk_cfg_load: assert property (@(posedge CLK) disable iff (!RST_B)
        (init_done && !restart_pulse) |=> active_cfg == $past(config_word))
        else $error("staged settings not applied at init");

    chk_cfg_write: assert property (@(posedge CLK) disable iff (!RST_B)
        (apb_done && PWRITE && hit_config) |=> {16'h0000, config_word} == ($past(PWDATA) & 32'h0000ffff))
        else $error("settings write not staged");

    chk_stop_no_conv: assert property (@(posedge CLK) disable iff (!RST_B)
        (state == ST_STOP) |-> CONV_OUT == 16'h0000)
        else $error("conversion data while stopped");

    chk_restart_zero: assert property (@(posedge CLK) disable iff (!RST_B)
        restart_now |=> CONV_OUT == 16'h0000)
        else $error("conversion data not zero with restart bit on");

    chk_bad_unit_deaf: assert property (@(posedge CLK) disable iff (!RST_B)
        !unit_ok(unit) |-> !restart_now)
        else $error("restart bit seen for invalid unit");

endmodule

// [unit_error_restart_control_bench.sv]
/*
 * self-checking bench of the unit error and restart control.
 * assumes the host model for acks and restart bits; apb tasks for registers.
 */
`timescale 1ns/1ps
module unit_error_restart_control_bench;
    import unit_error_restart_pkg::*;
    logic        CLK, RST_B, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er;
    logic        DUPLICATE_UNIT, HOST_ACK, CONV_VALID, RUN_IND, HOST_ERR_IND, ack_on;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [6:0]  UNIT_NUMBER;
    logic [7:0]  TABLE_TYPE;
    logic [95:0] RESTART_ARRAY;
    logic [15:0] CONV_DATA, CONV_OUT;
    int          err_count = 0;
    int          check_count = 0;

    unit_error_restart_control #(.SUPERVISION(20), .FITTED_TYPE(8'h5a)) dut (
        .CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .UNIT_NUMBER(UNIT_NUMBER), .DUPLICATE_UNIT(DUPLICATE_UNIT), .TABLE_TYPE(TABLE_TYPE),
        .HOST_ACK(HOST_ACK), .RESTART_ARRAY(RESTART_ARRAY), .CONV_DATA(CONV_DATA),
        .CONV_VALID(CONV_VALID), .CONV_OUT(CONV_OUT), .RUN_IND(RUN_IND), .HOST_ERR_IND(HOST_ERR_IND));
    host_model host (.CLK(CLK), .ack_on(ack_on), .HOST_ACK(HOST_ACK), .RESTART_ARRAY(RESTART_ARRAY));

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    // ************************************
    // tasks
    // ************************************
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        @(negedge CLK);
    endtask

    task automatic conv(input logic [15:0] d);
        @(posedge CLK);
        CONV_DATA <= d;
        CONV_VALID <= 1'b1;
        @(posedge CLK);
        CONV_VALID <= 1'b0;
        tick(1);
    endtask

    task automatic setup(input logic [6:0] n, input logic [7:0] t, input logic d, input logic a);
        @(posedge CLK);
        UNIT_NUMBER <= n;
        TABLE_TYPE <= t;
        DUPLICATE_UNIT <= d;
        ack_on <= a;
    endtask

    task automatic reset_dut();
        @(posedge CLK);
        RST_B <= 1'b0;
        repeat (10) @(posedge CLK);
        RST_B <= 1'b1;
        tick(110);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge CLK);
        err_count++;
        results();
    end

    // ************************************
    // tests
    // ************************************
    initial begin
        {RST_B, PSEL, PENABLE, PWRITE, CONV_VALID} = 5'h0;
        PADDR = 12'h000;
        PWDATA = 32'h0;
        CONV_DATA = 16'h0;
        setup(7'd37, 8'h5a, 1'b0, 1'b1);
        reset_dut();
        chk("run_after_power_on", 1, RUN_IND);
        apb(0, REG_STATUS, 0);
        chk("status_running", 32'h2508, rd);
        conv(16'h1234);
        chk("conv_out", 32'h1234, CONV_OUT);
        apb(0, REG_CONV, 0);
        chk("conv_reg", 32'h1234, rd);
        apb(0, 12'h010, 0);
        chk("unmapped_err", 1, er);
        apb(1, REG_CONFIG, 0);
        apb(0, REG_ACTIVE, 0);
        chk("active_staged", 1, rd);
        host.restart(36);
        tick(5);
        chk("other_unit_bit", 1, RUN_IND);
        host.restart(37);
        tick(2);
        chk("conv_zero_restart", 0, CONV_OUT);
        chk("run_off_restart", 0, RUN_IND);
        apb(0, REG_STATUS, 0);
        chk("status_restarting", 32'h2510, rd);
        tick(110);
        chk("run_after_restart", 1, RUN_IND);
        apb(0, REG_ACTIVE, 0);
        chk("active_applied", 0, rd);
        conv(16'h5678);
        chk("conv_disabled", 0, CONV_OUT);
        apb(1, REG_CONFIG, 1);
        host.restart(37);
        tick(112);
        conv(16'h5678);
        chk("conv_enabled", 32'h5678, CONV_OUT);
        setup(7'd37, 8'h5a, 1'b0, 1'b0);
        tick(25);
        chk("host_err", 1, HOST_ERR_IND);
        conv(16'h9abc);
        chk("conv_held", 32'h5678, CONV_OUT);
        setup(7'd37, 8'h5a, 1'b0, 1'b1);
        host.restart(37);
        tick(112);
        chk("host_err_cleared", 0, HOST_ERR_IND);
        setup(7'd37, 8'h33, 1'b0, 1'b1);
        host.restart(37);
        tick(112);
        chk("run_type_err", 0, RUN_IND);
        apb(0, REG_STATUS, 0);
        chk("status_type_err", 32'h2502, rd);
        setup(7'd37, 8'h5a, 1'b1, 1'b1);
        host.restart(37);
        tick(112);
        apb(0, REG_STATUS, 0);
        chk("status_dup_err", 32'h2504, rd);
        setup(7'd95, 8'h5a, 1'b0, 1'b1);
        host.restart(37);
        tick(112);
        chk("run_unit_95", 1, RUN_IND);
        apb(0, REG_STATUS, 0);
        chk("status_unit_95", 32'h5f08, rd);
        host.restart(95);
        tick(2);
        chk("restart_unit_95", 0, RUN_IND);
        tick(110);
        setup(7'd96, 8'h5a, 1'b0, 1'b1);
        reset_dut();
        chk("run_bad_unit", 0, RUN_IND);
        apb(0, REG_STATUS, 0);
        chk("status_bad_unit", 1, rd[STS_DUP_ERR]);
        results();
    end
endmodule

// [unit_error_restart_pkg.sv]
/*
 * constants, register map and state codes of the unit error and restart control.
 * assumes a 100 MHz clock; offsets are APB byte addresses.
 */
package unit_error_restart_pkg;

    // *****************************************
    // timing
    // *****************************************
    localparam int CLK_FREQ_MHZ       = 100;
    localparam int SUPERVISION_US     = 100;
    localparam int SUPERVISION_CYCLES = SUPERVISION_US * CLK_FREQ_MHZ;
    localparam int INIT_NS            = 1000;
    localparam int INIT_CYCLES        = (INIT_NS * CLK_FREQ_MHZ + 999) / 1000;

    // *****************************************
    // restart bit array and unit numbers
    // *****************************************
    localparam int UNIT_MAX      = 95;
    localparam int RESTART_WORDS = 6;
    localparam int WORD_BITS     = 16;

    // *****************************************
    // register map
    // *****************************************
    localparam logic [11:0] REG_CONFIG = 12'h000;
    localparam logic [11:0] REG_ACTIVE = 12'h004;
    localparam logic [11:0] REG_STATUS = 12'h008;
    localparam logic [11:0] REG_CONV   = 12'h00c;

    localparam logic [15:0] CONFIG_RESET   = 16'h0001;
    localparam int          CFG_ENABLE_BIT = 0;

    localparam int STS_HOST_ERR   = 0;
    localparam int STS_TYPE_ERR   = 1;
    localparam int STS_DUP_ERR    = 2;
    localparam int STS_RUN        = 3;
    localparam int STS_RESTARTING = 4;
    localparam int STS_UNIT_LSB   = 8;

    typedef enum logic [2:0] {
        ST_INIT = 3'b001,
        ST_RUN  = 3'b010,
        ST_STOP = 3'b100
    } unit_state_t;

endpackage
